//--- design/pss_pkg.sv
// Shared constants, timing figures and types of the power state sequencer.
package pss_pkg;
    // Internal clock rate and delay counter width.
    localparam int CLK_KHZ = 25000;
    localparam int DLY_W = 20;
    // Sequence delays in microseconds; t1 is the 500 us debounce plus 100 us wake-up.
    localparam int T1_US = 600;
    localparam int T2_US = 8000;
    localparam int T3_US = 4000;
    localparam int T4_US = 16000;
    localparam int RECOVER_US = 32000;
    // Least times round up, the longest wait for a failing rail rounds down.
    localparam int T1_CYC = (T1_US * CLK_KHZ + 999) / 1000;
    localparam int T2_CYC = (T2_US * CLK_KHZ + 999) / 1000;
    localparam int T3_CYC = (T3_US * CLK_KHZ + 999) / 1000;
    localparam int T4_CYC = (T4_US * CLK_KHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_US * CLK_KHZ) / 1000;
    // Rail enable patterns.
    localparam logic [2:0] RAILS_OFF = 3'h0;
    localparam logic [2:0] HIB_RAILS = 3'h2;
    localparam logic [2:0] ALL_RAILS = 3'h7;
    // Default rail voltages in millivolts.
    localparam logic [11:0] DDR_MV_LOW = 12'h4b0;
    localparam logic [11:0] DDR_MV_FLOAT = 12'h546;
    localparam logic [11:0] DDR_MV_HIGH = 12'h708;
    localparam logic [11:0] CORE_MV_LOW = 12'h3e8;
    localparam logic [11:0] CORE_MV_FLOAT = 12'h47e;
    localparam logic [11:0] CORE_MV_HIGH = 12'h4e2;
    // Three-level select pin as reported by the analog detector.
    typedef enum logic [1:0] {PSS_PIN_LOW, PSS_PIN_FLOAT, PSS_PIN_HIGH} pss_pin_t;
    typedef enum logic [3:0] {
        ST_OFF, ST_HIB, ST_WAIT_T1, ST_RAMP1, ST_WAIT_T2, ST_RAMP2,
        ST_WAIT_T3, ST_RAMP3, ST_WAIT_T4, ST_RUN, ST_DOWN
    } pss_state_t;
endpackage

//--- design/pss_sequencer.sv
// Power state decoder and three-rail start-up sequencer with reset output control.
//
// Overview of operation
// - Reset lands in off: rails off, reset low.
// - Hibernate keeps only rail two, pulse-skip.
// - Low-power: all rails pulse-skip, reset released.
// - Active: all rails forced fixed frequency.
// - Aux regulator follows only its enable pin.
// - DDR select pin picks 1.2/1.35/1.8 V.
// - Core select pin picks 1.0/1.15/1.25 V.
// - Select pins frozen from supply good until lost.
// - Reset released t4 after rail three good.
// - Undervoltage, system fault, overcurrent force reset low.
// - Rail two starts t2 after rail one good.
// - Rail three starts last, t3 after two.
// - Button must stay low through t1.
// - Button ignored once rail one started.
// - Power hold rising edge also starts sequence.
// - Hold low at release due: turn off, or hibernate on low-power request.
// - Delays come from programmed options, defaults else.
// - Start echo pulls low while button low.
// - Invalid start at t1 aborts before rails.
// - Failing rail gets 32 ms, then off.
// - Hold drop: reset low, then rails off, or hibernate on low-power request.
`timescale 1ns/1ps
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int T1_CYCLES = T1_CYC,
    parameter int T2_CYCLES = T2_CYC,
    parameter int T3_CYCLES = T3_CYC,
    parameter int T4_CYCLES = T4_CYC,
    parameter int RECOVER_CYCLES = RECOVER_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic undervoltage_lockout_ok,
    input wire logic system_fault,
    input wire logic [2:0] overcurrent,
    input wire logic [2:0] power_good,
    input wire logic power_hold,
    input wire logic low_power_request,
    input wire logic aux_regulator_enable,
    input wire logic start_button_n,
    input wire pss_pin_t ddr_rail_select,
    input wire pss_pin_t core_rail_select,
    input wire logic otp_override,
    input wire logic [3:0][DLY_W-1:0] otp_delay,
    input wire logic reset_out_n_i,
    input wire logic start_echo_n_i,
    output logic reset_out_n_o,
    output logic reset_out_n_oe,
    output logic start_echo_n_o,
    output logic start_echo_n_oe,
    output logic [2:0] buck_en,
    output logic [2:0] forced_fixed_frequency,
    output logic aux_ldo_en,
    output logic [11:0] ddr_rail_mv,
    output logic [11:0] core_rail_mv
);
    initial begin
        if (T1_CYCLES < 1 || T2_CYCLES < 1 || T3_CYCLES < 1 || T4_CYCLES < 1 ||
            RECOVER_CYCLES < 1 ||
            (T1_CYCLES | T2_CYCLES | T3_CYCLES | T4_CYCLES | RECOVER_CYCLES) >= (1 << DLY_W)) begin
            $error("pss_sequencer: delay counts must be 1 to 2**DLY_W-1");
        end
    end

    pss_state_t state;
    pss_state_t next_state;
    logic hold_prev;
    logic hold_rise;
    logic src_button;
    logic fault;
    logic start_bad;
    logic frozen;
    logic [2:0] seq_rails;
    logic [DLY_W-1:0] dly [4];

    pss_timer_if tif ();

    pss_timer u_timer (
        .clk (clk),
        .rst_n (rst_n),
        .t (tif.tmr)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    assign hold_rise = power_hold && !hold_prev;
    assign fault = !undervoltage_lockout_ok || system_fault || (|overcurrent);

    // The start cause decides which level must persist through t1.
    assign start_bad = src_button ? start_button_n : !power_hold;

    // Programmed delay options override the build-time defaults.
    always_comb begin
        dly[0] = otp_override ? otp_delay[0] : DLY_W'(T1_CYCLES);
        dly[1] = otp_override ? otp_delay[1] : DLY_W'(T2_CYCLES);
        dly[2] = otp_override ? otp_delay[2] : DLY_W'(T3_CYCLES);
        dly[3] = otp_override ? otp_delay[3] : DLY_W'(T4_CYCLES);
    end

    // The timer restarts on every state change, so no stale expiry carries over.
    always_comb begin
        tif.load = (next_state != state);
        case (next_state)
            ST_WAIT_T1: tif.period = dly[0];
            ST_WAIT_T2: tif.period = dly[1];
            ST_WAIT_T3: tif.period = dly[2];
            ST_WAIT_T4: tif.period = dly[3];
            default: tif.period = DLY_W'(RECOVER_CYCLES);
        endcase
    end

    always_comb begin
        next_state = state;
        if (fault) begin
            next_state = ST_OFF;
        end else begin
            case (state)
                ST_OFF: begin
                    if (hold_rise || !start_button_n) begin
                        next_state = ST_WAIT_T1;
                    end
                end
                ST_HIB: begin
                    if (!low_power_request) begin
                        next_state = ST_OFF;
                    end else if (hold_rise) begin
                        next_state = ST_WAIT_T1;
                    end
                end
                ST_WAIT_T1: begin
                    if (start_bad) begin
                        next_state = (buck_en[1] && low_power_request) ? ST_HIB : ST_OFF;
                    end else if (tif.done) begin
                        next_state = ST_RAMP1;
                    end
                end
                ST_RAMP1: begin
                    if (power_good[0]) begin
                        next_state = ST_WAIT_T2;
                    end else if (tif.done) begin
                        next_state = ST_OFF;
                    end
                end
                ST_WAIT_T2: begin
                    if (tif.done) begin
                        next_state = ST_RAMP2;
                    end
                end
                ST_RAMP2: begin
                    if (power_good[1]) begin
                        next_state = ST_WAIT_T3;
                    end else if (tif.done) begin
                        next_state = ST_OFF;
                    end
                end
                ST_WAIT_T3: begin
                    if (tif.done) begin
                        next_state = ST_RAMP3;
                    end
                end
                ST_RAMP3: begin
                    if (power_good[2]) begin
                        next_state = ST_WAIT_T4;
                    end else if (tif.done) begin
                        next_state = ST_OFF;
                    end
                end
                ST_WAIT_T4: begin
                    // Rail status is checked again as t4 expires.
                    if (tif.done) begin
                        next_state = (power_hold && (&power_good)) ? ST_RUN : ST_DOWN;
                    end
                end
                ST_RUN: begin
                    if (!power_hold) begin
                        next_state = ST_DOWN;
                    end
                end
                ST_DOWN: begin
                    next_state = low_power_request ? ST_HIB : ST_OFF;
                end
                default: next_state = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // The button plays no part after t1, so only the entry cause is kept.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_prev <= 1'b0;
            src_button <= 1'b0;
        end else begin
            hold_prev <= power_hold;
            if (next_state == ST_WAIT_T1 && state != ST_WAIT_T1) begin
                src_button <= !hold_rise;
            end
        end
    end

    // Rail two stays up when a start begins from hibernate.
    always_comb begin
        seq_rails[0] = (next_state >= ST_RAMP1);
        seq_rails[1] = (next_state >= ST_RAMP2) || buck_en[1];
        seq_rails[2] = (next_state >= ST_RAMP3);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buck_en <= RAILS_OFF;
            forced_fixed_frequency <= RAILS_OFF;
        end else begin
            case (next_state)
                ST_OFF: begin
                    buck_en <= RAILS_OFF;
                    forced_fixed_frequency <= RAILS_OFF;
                end
                ST_HIB: begin
                    buck_en <= HIB_RAILS;
                    forced_fixed_frequency <= RAILS_OFF;
                end
                ST_DOWN: begin
                    // Rails are held for this one cycle so reset falls first.
                    buck_en <= buck_en;
                    forced_fixed_frequency <= forced_fixed_frequency;
                end
                default: begin
                    buck_en <= seq_rails;
                    forced_fixed_frequency <= low_power_request ? RAILS_OFF : seq_rails;
                end
            endcase
        end
    end

    // Reset is released only in the run state, so every other path keeps it low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reset_out_n_o <= 1'b0;
            reset_out_n_oe <= 1'b1;
            start_echo_n_o <= 1'b0;
            start_echo_n_oe <= 1'b0;
            aux_ldo_en <= 1'b0;
        end else begin
            reset_out_n_o <= 1'b0;
            reset_out_n_oe <= (next_state != ST_RUN);
            start_echo_n_o <= 1'b0;
            start_echo_n_oe <= !start_button_n;
            aux_ldo_en <= aux_regulator_enable;
        end
    end

    function automatic logic [11:0] pick_mv(input pss_pin_t p, input logic [11:0] lo,
                                            input logic [11:0] fl, input logic [11:0] hi);
        case (p)
            PSS_PIN_LOW: pick_mv = lo;
            PSS_PIN_HIGH: pick_mv = hi;
            default: pick_mv = fl;
        endcase
    endfunction

    // The snapshot is taken in the first cycle of supply good, so pins that settle later are ignored.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frozen <= 1'b0;
            ddr_rail_mv <= DDR_MV_FLOAT;
            core_rail_mv <= CORE_MV_FLOAT;
        end else if (!undervoltage_lockout_ok) begin
            frozen <= 1'b0;
        end else if (!frozen) begin
            frozen <= 1'b1;
            ddr_rail_mv <= pick_mv(ddr_rail_select, DDR_MV_LOW, DDR_MV_FLOAT, DDR_MV_HIGH);
            core_rail_mv <= pick_mv(core_rail_select, CORE_MV_LOW, CORE_MV_FLOAT,
                                    CORE_MV_HIGH);
        end
    end

    sequence s_hold_drop;
        state == ST_RUN && !power_hold && !fault;
    endsequence

    sequence s_reset_first;
        state == ST_DOWN && reset_out_n_oe && buck_en == $past(buck_en);
    endsequence

    sequence s_rails_off;
        buck_en[0] == 1'b0 && buck_en[2] == 1'b0;
    endsequence

    AST_OFF_STATE: assert property (
        state == ST_OFF |-> buck_en == RAILS_OFF && reset_out_n_oe)
        else $error("off state with a rail on or reset released");

    AST_HIBERNATE: assert property (
        state == ST_HIB |-> buck_en == HIB_RAILS && forced_fixed_frequency == RAILS_OFF &&
            reset_out_n_oe)
        else $error("hibernate outputs wrong");

    AST_LOW_POWER: assert property (
        state == ST_RUN && $past(state) == ST_RUN && $past(low_power_request) |->
            buck_en == ALL_RAILS && forced_fixed_frequency == RAILS_OFF && !reset_out_n_oe)
        else $error("low-power mode outputs wrong");

    AST_ACTIVE: assert property (
        state == ST_RUN && $past(state) == ST_RUN && !$past(low_power_request) |->
            forced_fixed_frequency == ALL_RAILS && !reset_out_n_oe)
        else $error("active mode outputs wrong");

    AST_AUX_PIN: assert property (
        $changed(aux_regulator_enable) && !$changed(power_hold) |=>
            aux_ldo_en == $past(aux_regulator_enable))
        else $error("aux regulator did not follow its pin");

    AST_SELECT_FROZEN: assert property (
        frozen && $past(frozen) |-> $stable(ddr_rail_mv) && $stable(core_rail_mv))
        else $error("rail voltage changed while frozen");

    AST_RESET_RELEASE: assert property (
        $fell(reset_out_n_oe) |-> $past(state) == ST_WAIT_T4 && $past(tif.done) &&
            $past(power_hold) && buck_en == ALL_RAILS)
        else $error("reset released outside t4 expiry");

    AST_FAULT_RESET: assert property (
        fault |=> reset_out_n_oe && state == ST_OFF)
        else $error("fault did not force reset low");

    AST_RAIL2_ORDER: assert property (
        $rose(buck_en[1]) |-> buck_en[0] && $past(state) == ST_WAIT_T2 && $past(tif.done))
        else $error("rail two started out of order");

    AST_RAIL3_ORDER: assert property (
        $rose(buck_en[2]) |-> buck_en[1:0] == 2'h3 && $past(state) == ST_WAIT_T3)
        else $error("rail three started out of order");

    AST_BUTTON_ABORT: assert property (
        state == ST_WAIT_T1 && src_button && start_button_n && !buck_en[1] |=>
            state == ST_OFF && buck_en == RAILS_OFF)
        else $error("released button did not abort the start");

    AST_BUTTON_IGNORED: assert property (
        state == ST_WAIT_T2 && !fault && !tif.done |=> state == ST_WAIT_T2)
        else $error("sequence left a wait step early");

    AST_HOLD_START: assert property (
        state == ST_OFF && hold_rise && !fault |=> state == ST_WAIT_T1 && !src_button)
        else $error("power hold edge did not start the sequence");

    AST_NO_HOLD_OFF: assert property (
        state == ST_WAIT_T4 && tif.done && !power_hold && !fault |=>
            state == ST_DOWN && reset_out_n_oe)
        else $error("missing power hold did not turn off");

    AST_RECOVER_ABORT: assert property (
        state == ST_RAMP1 && tif.done && !power_good[0] && !fault |=> state == ST_OFF)
        else $error("failing rail did not abort after the window");

    AST_HOLD_DROP: assert property (
        s_hold_drop |=> s_reset_first ##1 s_rails_off)
        else $error("hold drop did not lower reset before the rails");

    AST_ECHO: assert property (
        $fell(start_button_n) |=> start_echo_n_oe ##1 start_echo_n_oe == !$past(start_button_n))
        else $error("start echo did not follow the button");
endmodule

//--- design/pss_timer.sv
// Down-counting delay timer shared by all sequence steps.
`timescale 1ns/1ps
module pss_timer
    import pss_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    pss_timer_if.tmr t
);
    logic [DLY_W-1:0] cnt;

    // A load restarts the count; done is seen period cycles after the load edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (t.load) begin
            cnt <= t.period;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign t.done = (cnt == '0);
endmodule

//--- design/pss_timer_if.sv
// Link between the sequencer and its delay timer.
`timescale 1ns/1ps
interface pss_timer_if;
    import pss_pkg::*;
    logic load;
    logic [DLY_W-1:0] period;
    logic done;
    modport ctrl (output load, output period, input done);
    modport tmr (input load, input period, output done);
endinterface

//--- dv/pss_rail_model.sv
// Behavioural model of the three buck rails reporting power-good back to the sequencer.
`timescale 1ns/1ps
module pss_rail_model #(
    parameter int PG_DELAY = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] buck_en,
    input wire logic [2:0] fail_mask,
    output logic [2:0] power_good
);
    int cnt [3];

    // A rail reports good a few cycles after it is enabled, never while it is told to fail.
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (!rst_n || !buck_en[i] || fail_mask[i]) begin
                cnt[i] <= 0;
                power_good[i] <= 1'b0;
            end else if (cnt[i] == PG_DELAY) begin
                power_good[i] <= 1'b1;
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule

//--- dv/testbench.sv
// Self-checking testbench of the power state sequencer with a rail model.
`timescale 1ns/1ps
module testbench;
    import pss_pkg::*;
    localparam int T1 = 4;
    localparam int T2 = 6;
    localparam int T3 = 5;
    localparam int T4 = 8;
    localparam int REC = 20;
    localparam int PGD = 3;
    logic clk, rst_n, undervoltage_lockout_ok, system_fault, power_hold, low_power_request;
    logic aux_regulator_enable, start_button_n, otp_override;
    logic [2:0] overcurrent, power_good, fail_mask, buck_en, forced_fixed_frequency;
    pss_pin_t ddr_rail_select, core_rail_select;
    logic [3:0][DLY_W-1:0] otp_delay;
    logic reset_out_n_o, reset_out_n_oe, start_echo_n_o, start_echo_n_oe, aux_ldo_en;
    logic [11:0] ddr_rail_mv, core_rail_mv;
    int bad_count, total_checks, cycles;
    logic watch_rst, rst_seen;
    logic [11:0] ddr_exp [3];
    logic [11:0] core_exp [3];

    pss_sequencer #(.T1_CYCLES(T1), .T2_CYCLES(T2), .T3_CYCLES(T3), .T4_CYCLES(T4),
        .RECOVER_CYCLES(REC)) DUT (
        .clk(clk), .rst_n(rst_n), .undervoltage_lockout_ok(undervoltage_lockout_ok), .system_fault(system_fault),
        .overcurrent(overcurrent), .power_good(power_good), .power_hold(power_hold),
        .low_power_request(low_power_request), .aux_regulator_enable(aux_regulator_enable),
        .start_button_n(start_button_n), .ddr_rail_select(ddr_rail_select),
        .core_rail_select(core_rail_select), .otp_override(otp_override),
        .otp_delay(otp_delay), .reset_out_n_i(~reset_out_n_oe),
        .start_echo_n_i(~start_echo_n_oe), .reset_out_n_o(reset_out_n_o),
        .reset_out_n_oe(reset_out_n_oe), .start_echo_n_o(start_echo_n_o),
        .start_echo_n_oe(start_echo_n_oe), .buck_en(buck_en),
        .forced_fixed_frequency(forced_fixed_frequency), .aux_ldo_en(aux_ldo_en),
        .ddr_rail_mv(ddr_rail_mv), .core_rail_mv(core_rail_mv));

    pss_rail_model #(.PG_DELAY(PGD)) rails (.clk(clk), .rst_n(rst_n), .buck_en(buck_en),
        .fail_mask(fail_mask), .power_good(power_good));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // A hang is cut short so that a stuck sequencer still yields a verdict.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    always @(negedge clk) begin
        if (watch_rst && reset_out_n_oe === 1'b0) rst_seen = 1'b1;
    end

    task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Counts cycles until buck_en (sel 0) or the reset pull-down (sel 1) reaches val.
    task automatic wait_out(input string name, input int sel, input logic [2:0] val,
                            input int lo, input int hi);
        int n;
        n = 0;
        @(negedge clk);
        while (((sel == 0) ? buck_en : {2'h0, reset_out_n_oe}) !== val && n <= hi) begin
            @(negedge clk);
            n++;
        end
        total_checks++;
        if (n < lo || n > hi) begin
            bad_count++;
            $display("MISMATCH %s expected %0d to %0d cycles seen %0d", name, lo, hi, n);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask

    task automatic hold_start();
        @(posedge clk) power_hold <= 1'b1;
        wait_out("all rails", 0, 3'h7, 0, 80);
        wait_out("reset release", 1, 3'h0, 0, 40);
    endtask

    task automatic go_off();
        @(posedge clk) begin
            power_hold <= 1'b0;
            low_power_request <= 1'b0;
        end
        wait_out("rails off", 0, 3'h0, 0, 4);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        ddr_exp = '{DDR_MV_LOW, DDR_MV_FLOAT, DDR_MV_HIGH};
        core_exp = '{CORE_MV_LOW, CORE_MV_FLOAT, CORE_MV_HIGH};
        {rst_n, undervoltage_lockout_ok, system_fault, power_hold, low_power_request} = 5'h0;
        {aux_regulator_enable, otp_override, watch_rst, rst_seen} = 4'h0;
        start_button_n = 1'b1;
        overcurrent = 3'h0;
        fail_mask = 3'h0;
        ddr_rail_select = PSS_PIN_FLOAT;
        core_rail_select = PSS_PIN_FLOAT;
        otp_delay = '0;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        check("buck_en", 3'h0, buck_en);
        check("reset pull", 1'b1, reset_out_n_oe);
        check("echo pull", 1'b0, start_echo_n_oe);
        check("reset drive", 1'b0, reset_out_n_o);
        check("echo drive", 1'b0, start_echo_n_o);
        test_end("reset");

        for (int i = 0; i < 3; i++) begin
            @(posedge clk) undervoltage_lockout_ok <= 1'b0;
            @(posedge clk) begin
                ddr_rail_select <= pss_pin_t'(i);
                core_rail_select <= pss_pin_t'(i);
                undervoltage_lockout_ok <= 1'b1;
            end
            settle(3);
            check("ddr mv", ddr_exp[i], ddr_rail_mv);
            check("core mv", core_exp[i], core_rail_mv);
            @(posedge clk) ddr_rail_select <= pss_pin_t'((i + 1) % 3);
            settle(3);
            check("ddr frozen", ddr_exp[i], ddr_rail_mv);
        end
        test_end("select pins");

        @(posedge clk) start_button_n <= 1'b0;
        settle(2);
        check("echo pull", 1'b1, start_echo_n_oe);
        wait_out("rail1 start", 0, 3'h1, T1 - 1, T1 + 3);
        @(posedge clk) start_button_n <= 1'b1;
        @(posedge clk) start_button_n <= 1'b0;
        @(posedge clk) begin
            start_button_n <= 1'b1;
            power_hold <= 1'b1;
        end
        wait_out("rail2 start", 0, 3'h3, T2 + PGD - 3, T2 + PGD + 5);
        wait_out("rail3 start", 0, 3'h7, T3 + PGD - 1, T3 + PGD + 5);
        wait_out("reset release", 1, 3'h0, T4 + PGD - 1, T4 + PGD + 5);
        check("fixed freq", 3'h7, forced_fixed_frequency);
        @(posedge clk) start_button_n <= 1'b0;
        settle(3);
        check("echo in run", 1'b1, start_echo_n_oe);
        check("rails in run", 3'h7, buck_en);
        @(posedge clk) begin
            start_button_n <= 1'b1;
            low_power_request <= 1'b1;
        end
        settle(3);
        check("pulse skip", 3'h0, forced_fixed_frequency);
        check("low power rails", 3'h7, buck_en);
        check("low power reset", 1'b0, reset_out_n_oe);
        test_end("button start");

        @(posedge clk) power_hold <= 1'b0;
        wait_out("reset on drop", 1, 3'h1, 0, 2);
        wait_out("hibernate rails", 0, HIB_RAILS, 0, 3);
        check("hibernate mode", 3'h0, forced_fixed_frequency);
        check("hibernate reset", 1'b1, reset_out_n_oe);
        @(posedge clk) aux_regulator_enable <= 1'b1;
        settle(2);
        check("aux on", 1'b1, aux_ldo_en);
        @(posedge clk) aux_regulator_enable <= 1'b0;
        settle(2);
        check("aux off", 1'b0, aux_ldo_en);
        hold_start();
        @(posedge clk) low_power_request <= 1'b0;
        settle(3);
        check("active from hib", 3'h7, forced_fixed_frequency);
        go_off();
        check("off reset", 1'b1, reset_out_n_oe);
        test_end("hibernate");

        @(posedge clk) start_button_n <= 1'b0;
        settle(2);
        @(posedge clk) start_button_n <= 1'b1;
        settle(T1 + 10);
        check("short press", 3'h0, buck_en);
        test_end("short press");

        watch_rst = 1'b1;
        @(posedge clk) start_button_n <= 1'b0;
        wait_out("rail1 no hold", 0, 3'h1, T1 - 1, T1 + 3);
        @(posedge clk) start_button_n <= 1'b1;
        wait_out("rails no hold", 0, 3'h7, 0, 60);
        wait_out("turn off no hold", 0, 3'h0, T4, T4 + PGD + 8);
        watch_rst = 1'b0;
        check("reset kept low", 1'b0, rst_seen);
        test_end("no hold");

        for (int k = 0; k < 5; k++) begin
            hold_start();
            @(posedge clk) begin
                if (k == 0) undervoltage_lockout_ok <= 1'b0;
                if (k == 1) system_fault <= 1'b1;
                if (k > 1) overcurrent <= 3'h1 << (k - 2);
            end
            wait_out("fault reset", 1, 3'h1, 0, 1);
            wait_out("fault rails", 0, 3'h0, 0, 2);
            @(posedge clk) begin
                undervoltage_lockout_ok <= 1'b1;
                system_fault <= 1'b0;
                overcurrent <= 3'h0;
            end
            go_off();
        end
        test_end("faults");

        @(posedge clk) fail_mask <= 3'h1;
        @(posedge clk) power_hold <= 1'b1;
        wait_out("rail1 failing", 0, 3'h1, T1 - 1, T1 + 3);
        wait_out("recovery abort", 0, 3'h0, REC - 2, REC + 4);
        @(posedge clk) fail_mask <= 3'h0;
        go_off();
        test_end("recovery");

        @(posedge clk) begin
            otp_override <= 1'b1;
            otp_delay <= {20'h0000c, 20'h00009, 20'h0000b, 20'h00010};
        end
        @(posedge clk) power_hold <= 1'b1;
        wait_out("otp t1", 0, 3'h1, 15, 19);
        wait_out("otp t2", 0, 3'h3, 11 + PGD, 11 + PGD + 4);
        wait_out("otp t3", 0, 3'h7, 9 + PGD, 9 + PGD + 4);
        wait_out("otp t4", 1, 3'h0, 12 + PGD, 12 + PGD + 4);
        go_off();
        test_end("otp delays");
        end_of_test();
    end
endmodule
